/* File: rtl/xmb_bus.sv */
// External memory bus sequencer with register file and address decode
`timescale 1ns/1ps
// Operation
// R1: addr_strobe pulses low once at the start of every machine cycle.
// R2: Low address byte is on port 1 before addr_strobe rises.
// R3: Software can float strobes, read/write and address ports together.
// R4: data_strobe goes low once for each external memory transfer.
// R5: write_not_read is low during external writes, high otherwise.
// R6: After reset release fetching starts at program address 000c.
// R7: Program counter is 16 bits covering 64K bytes.
// R8: Fetches below 2048 use on-chip ROM, others go external.
// R9: Lowest 12 program bytes hold six 16-bit interrupt vectors.
// R10: Data memory is all external, up to 62K from 2048.
// R11: Optional data_space_select on port3_line4 marks data accesses.
// R12: Ports at 0-3, general registers 4-127, control 240-255.
// R13: Any register reachable through a full 8-bit address.
// R14: Short address is pointer group plus 4-bit field; nine groups.
// R15: External stack uses 16-bit pointer from registers 254 and 255.
// R16: Internal stack uses register 255 only, in general registers.
// R17: Port 0 drives address bits 8-11, or 8-15 when configured.
// R18: Memory latches address on addr_strobe rise, data while strobe low.
// R19: Without data_space_select, program and data share one space.
module xmb_bus #(
   parameter int PHASE_DIV = 2
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Core transfer request
   input wire logic i_req_valid,
   input wire xmb_pkg::xmb_req_t i_req,
   output logic o_req_ready,
   output logic o_rsp_valid,
   output logic [7:0] o_rsp_data,
   // Program counter control
   input wire logic i_pc_load,
   input wire logic [15:0] i_pc_value,
   input wire logic i_vec_take,
   input wire logic [2:0] i_vec_id,
   output logic [15:0] o_pc,
   // On-chip ROM
   output logic [10:0] o_rom_addr,
   input wire logic [7:0] i_rom_data,
   // Register file port
   input wire logic i_rf_short,
   input wire logic [7:0] i_rf_addr,
   input wire logic [3:0] i_rf_field,
   input wire logic i_rf_we,
   input wire logic [7:0] i_rf_wdata,
   output logic [7:0] o_rf_rdata,
   // Memory strobes
   output xmb_pkg::xmb_strobe_t o_strobe,
   // Port 0 and port 1
   output logic [7:0] o_port0,
   output logic [7:0] o_port0_oe,
   input wire logic [7:0] i_port1,
   output logic [7:0] o_port1,
   output logic o_port1_oe,
   // Port 3 line 4
   output logic o_port3_line4
);
   ////////////////////////////////////////////////////////////////
   // Register file storage
   logic [7:0] rf_mem [0:xmb_pkg::RF_DEPTH-1];

   function automatic logic rf_mapped(input logic [7:0] a);
      rf_mapped = (a <= xmb_pkg::GP_LAST) || (a >= xmb_pkg::CTRL_FIRST);
   endfunction

   function automatic logic [7:0] rf_index(input logic [7:0] a);
      rf_index = (a <= xmb_pkg::GP_LAST) ? a : a - xmb_pkg::CTRL_GAP;
   endfunction

   logic [7:0] bus_mode;
   logic [7:0] p3_mode;
   logic [7:0] rp;
   logic [7:0] sp_hi;
   logic [7:0] sp_lo;
   logic [7:0] port0_data;
   logic [7:0] port3_data;
   assign bus_mode = rf_mem[rf_index(xmb_pkg::BUS_MODE)];
   assign p3_mode = rf_mem[rf_index(xmb_pkg::PORT3_MODE)];
   assign rp = rf_mem[rf_index(xmb_pkg::REG_POINTER)];
   assign sp_hi = rf_mem[rf_index(xmb_pkg::STACK_POINTER_HIGH)];
   assign sp_lo = rf_mem[rf_index(xmb_pkg::STACK_POINTER_LOW)];
   assign port0_data = rf_mem[rf_index(xmb_pkg::IO_PORT_ZERO_DATA)];
   assign port3_data = rf_mem[rf_index(xmb_pkg::IO_PORT_THREE_DATA)];

   logic bus_float;
   logic p0_full;
   logic stack_int;
   logic dm_en;
   assign bus_float = bus_mode[xmb_pkg::BUS_FLOAT_BIT];
   assign p0_full = bus_mode[xmb_pkg::P0_FULL_BIT];
   assign stack_int = bus_mode[xmb_pkg::STACK_INT_BIT];
   assign dm_en = p3_mode[xmb_pkg::DM_ENABLE_BIT];

   ////////////////////////////////////////////////////////////////
   // Port 1 input synchroniser
   logic [7:0] p1_meta_reg;
   logic [7:0] p1_sync_reg;
   always_ff @(posedge i_clk) begin
      p1_meta_reg <= i_port1;
      p1_sync_reg <= p1_meta_reg;
   end

   ////////////////////////////////////////////////////////////////
   // Phase divider
   logic [7:0] div_reg;
   logic [7:0] div_next;
   logic tick;
   assign tick = (div_reg == 8'(PHASE_DIV - 1));
   always_comb begin
      div_next = tick ? 8'h00 : div_reg + 8'h01;
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         div_reg <= 8'h00;
      end else begin
         div_reg <= div_next;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Machine cycle sequencer
   xmb_pkg::xmb_phase_t ph_reg, ph_next;
   logic [15:0] pc_reg, pc_next;
   logic cyc_ext_reg, cyc_ext_next;
   logic cyc_wr_reg, cyc_wr_next;
   logic cyc_data_reg, cyc_data_next;
   logic cyc_int_sp_reg, cyc_int_sp_next;
   logic cyc_sp_reg, cyc_sp_next;
   logic [15:0] req_addr;
   logic [1:0] cyc_kind_reg, cyc_kind_next;
   logic [15:0] cyc_addr_reg, cyc_addr_next;
   logic [7:0] cyc_wdata_reg, cyc_wdata_next;
   logic rsp_valid_reg, rsp_valid_next;
   logic [7:0] rsp_data_reg, rsp_data_next;
   logic [10:0] rom_addr_reg, rom_addr_next;
   logic take;
   logic done;
   logic [15:0] sp16;
   logic [7:0] sp_int_rd;
   assign sp16 = {sp_hi, sp_lo};
   assign take = (ph_reg == xmb_pkg::PH_T1) && tick && i_req_valid;
   assign done = (ph_reg == xmb_pkg::PH_T3) && tick && (cyc_kind_reg != 2'b00 || cyc_ext_reg);
   assign o_req_ready = (ph_reg == xmb_pkg::PH_T1) && tick;
   assign sp_int_rd = rf_mem[rf_index(sp_lo)];

   // Address of the pending request, shown on the pins during T1
   always_comb begin
      case (i_req.kind)
         xmb_pkg::KIND_FETCH: req_addr = pc_reg;
         xmb_pkg::KIND_DATA: req_addr = i_req.addr;
         xmb_pkg::KIND_PUSH: req_addr = sp16 - 16'h0001;
         default: req_addr = sp16;
      endcase
   end

   always_comb begin
      ph_next = ph_reg;
      pc_next = pc_reg;
      cyc_ext_next = cyc_ext_reg;
      cyc_wr_next = cyc_wr_reg;
      cyc_data_next = cyc_data_reg;
      cyc_int_sp_next = cyc_int_sp_reg;
      cyc_sp_next = cyc_sp_reg;
      cyc_kind_next = cyc_kind_reg;
      cyc_addr_next = cyc_addr_reg;
      cyc_wdata_next = cyc_wdata_reg;
      rsp_valid_next = 1'b0;
      rsp_data_next = rsp_data_reg;
      rom_addr_next = rom_addr_reg;
      if (tick) begin
         unique case (ph_reg)
            xmb_pkg::PH_T1: begin
               ph_next = xmb_pkg::PH_T2;
               cyc_kind_next = 2'b00;
               cyc_ext_next = 1'b0;
               cyc_wr_next = 1'b0;
               cyc_data_next = 1'b0;
               cyc_int_sp_next = 1'b0;
               cyc_sp_next = 1'b0;
               if (i_req_valid) begin
                  cyc_kind_next = 2'b01;
                  cyc_wdata_next = i_req.wdata;
                  unique case (i_req.kind)
                     xmb_pkg::KIND_FETCH: begin
                        cyc_addr_next = pc_reg;
                        cyc_ext_next = (pc_reg >= xmb_pkg::ROM_LIMIT); // R8
                        rom_addr_next = pc_reg[10:0];
                        pc_next = pc_reg + 16'h0001; // R7
                     end
                     xmb_pkg::KIND_DATA: begin
                        cyc_addr_next = i_req.addr;
                        cyc_ext_next = 1'b1; // R10
                        cyc_wr_next = i_req.write;
                        cyc_data_next = 1'b1;
                     end
                     xmb_pkg::KIND_PUSH: begin
                        cyc_addr_next = sp16 - 16'h0001; // R15
                        cyc_sp_next = 1'b1;
                        cyc_ext_next = !stack_int;
                        cyc_int_sp_next = stack_int; // R16
                        cyc_wr_next = 1'b1;
                        cyc_data_next = 1'b1;
                     end
                     xmb_pkg::KIND_POP: begin
                        cyc_addr_next = sp16; // R15
                        cyc_sp_next = 1'b1;
                        cyc_ext_next = !stack_int;
                        cyc_int_sp_next = stack_int; // R16
                        cyc_data_next = 1'b1;
                     end
                  endcase
               end
            end
            xmb_pkg::PH_T2: begin
               ph_next = xmb_pkg::PH_T3;
            end
            xmb_pkg::PH_T3: begin
               ph_next = xmb_pkg::PH_T1;
               if (cyc_kind_reg != 2'b00) begin
                  rsp_valid_next = 1'b1;
                  if (cyc_int_sp_reg) begin
                     rsp_data_next = cyc_wr_reg ? cyc_wdata_reg : sp_int_rd;
                  end else if (cyc_ext_reg) begin
                     rsp_data_next = cyc_wr_reg ? cyc_wdata_reg : p1_sync_reg;
                  end else begin
                     rsp_data_next = i_rom_data; // R8
                  end
               end
            end
            default: begin
               ph_next = xmb_pkg::PH_T1;
            end
         endcase
      end
      if (i_vec_take) begin
         pc_next = xmb_pkg::VEC_BASE + {12'h000, i_vec_id, 1'b0}; // R9
      end else if (i_pc_load) begin
         pc_next = i_pc_value; // R7
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         ph_reg <= xmb_pkg::PH_T1;
         pc_reg <= xmb_pkg::RESET_PC; // R6
         cyc_ext_reg <= 1'b0;
         cyc_wr_reg <= 1'b0;
         cyc_data_reg <= 1'b0;
         cyc_int_sp_reg <= 1'b0;
         cyc_sp_reg <= 1'b0;
         cyc_kind_reg <= 2'b00;
         cyc_addr_reg <= 16'h0000;
         cyc_wdata_reg <= 8'h00;
         rsp_valid_reg <= 1'b0;
         rsp_data_reg <= 8'h00;
         rom_addr_reg <= 11'h000;
      end else begin
         ph_reg <= ph_next;
         pc_reg <= pc_next;
         cyc_ext_reg <= cyc_ext_next;
         cyc_wr_reg <= cyc_wr_next;
         cyc_data_reg <= cyc_data_next;
         cyc_int_sp_reg <= cyc_int_sp_next;
         cyc_sp_reg <= cyc_sp_next;
         cyc_kind_reg <= cyc_kind_next;
         cyc_addr_reg <= cyc_addr_next;
         cyc_wdata_reg <= cyc_wdata_next;
         rsp_valid_reg <= rsp_valid_next;
         rsp_data_reg <= rsp_data_next;
         rom_addr_reg <= rom_addr_next;
      end
   end
   assign o_rsp_valid = rsp_valid_reg;
   assign o_rsp_data = rsp_data_reg;
   assign o_rom_addr = rom_addr_reg;
   assign o_pc = pc_reg;

   ////////////////////////////////////////////////////////////////
   // Register file access and stack pointer update
   logic [7:0] rf_ea;
   logic [7:0] rf_rdata_reg, rf_rdata_next;
   logic cyc_stack;
   logic [15:0] sp_new;
   assign rf_ea = i_rf_short ? {rp[7:4], i_rf_field} : i_rf_addr; // R13 R14
   assign cyc_stack = cyc_sp_reg;
   always_comb begin
      rf_rdata_next = 8'h00;
      if (rf_mapped(rf_ea)) begin
         rf_rdata_next = rf_mem[rf_index(rf_ea)]; // R12
         if (rf_ea == xmb_pkg::IO_PORT_ONE_DATA) begin
            rf_rdata_next = p1_sync_reg;
         end
      end
      sp_new = cyc_wr_reg ? cyc_addr_reg : cyc_addr_reg + 16'h0001;
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         rf_rdata_reg <= 8'h00;
      end else begin
         rf_rdata_reg <= rf_rdata_next;
      end
   end
   assign o_rf_rdata = rf_rdata_reg;

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         for (int i = rf_index(xmb_pkg::CTRL_FIRST); i < xmb_pkg::RF_DEPTH; i++) begin
            rf_mem[i] <= xmb_pkg::CTRL_RESET;
         end
      end else begin
         if (i_rf_we && rf_mapped(rf_ea)) begin
            rf_mem[rf_index(rf_ea)] <= i_rf_wdata; // R12 R13
         end
         if (done && cyc_int_sp_reg && cyc_wr_reg) begin
            rf_mem[rf_index(cyc_addr_reg[7:0])] <= cyc_wdata_reg; // R16
         end
         if (done && cyc_stack) begin
            rf_mem[rf_index(xmb_pkg::STACK_POINTER_LOW)] <= sp_new[7:0]; // R15 R16
            if (!cyc_int_sp_reg) begin
               rf_mem[rf_index(xmb_pkg::STACK_POINTER_HIGH)] <= sp_new[15:8]; // R15
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Pin drive
   logic in_t1;
   logic ext_act;
   logic [15:0] show_addr;
   assign in_t1 = (ph_reg == xmb_pkg::PH_T1);
   assign ext_act = cyc_ext_reg && !in_t1;
   assign show_addr = in_t1 ? req_addr : cyc_addr_reg; // R2
   always_comb begin
      o_strobe.as_b_o = !(in_t1 && div_reg < 8'(PHASE_DIV / 2 + PHASE_DIV % 2)); // R1
      o_strobe.ds_b_o = !ext_act; // R4
      o_strobe.rw_o = !(ext_act && cyc_wr_reg); // R5
      o_strobe.as_b_oe = !bus_float; // R3
      o_strobe.ds_b_oe = !bus_float;
      o_strobe.rw_oe = !bus_float;
      o_port1 = (ext_act && cyc_wr_reg) ? cyc_wdata_reg : show_addr[7:0]; // R2
      o_port1_oe = !bus_float && (in_t1 || (ext_act && cyc_wr_reg)); // R3 R18
      o_port0 = port0_data;
      o_port0_oe = 8'hff;
      o_port0[3:0] = show_addr[11:8]; // R17
      o_port0_oe[3:0] = {4{!bus_float}};
      if (p0_full) begin
         o_port0[7:4] = show_addr[15:12]; // R17
         o_port0_oe[7:4] = {4{!bus_float}};
      end
      o_port3_line4 = port3_data[xmb_pkg::P3_DM_LINE];
      if (dm_en) begin
         o_port3_line4 = !(cyc_ext_reg && cyc_data_reg); // R11
      end
      // R19
   end
endmodule

/* File: rtl/xmb_pkg.sv */
// Constants and carriers of the external memory bus sequencer
package xmb_pkg;
   ////////////////////////////////////////////////////////////////
   // Address spaces
   localparam logic [15:0] RESET_PC = 16'h000c;
   localparam logic [15:0] ROM_LIMIT = 16'h0800;
   localparam logic [15:0] VEC_BASE = 16'h0000;
   localparam int VEC_COUNT = 6;
   localparam int VEC_BYTES = 12;
   ////////////////////////////////////////////////////////////////
   // Register file map
   localparam logic [7:0] IO_PORT_ZERO_DATA = 8'h00;
   localparam logic [7:0] IO_PORT_ONE_DATA = 8'h01;
   localparam logic [7:0] IO_PORT_TWO_DATA = 8'h02;
   localparam logic [7:0] IO_PORT_THREE_DATA = 8'h03;
   localparam logic [7:0] GP_FIRST = 8'h04;
   localparam logic [7:0] GP_LAST = 8'h7f;
   localparam logic [7:0] CTRL_FIRST = 8'hf0;
   localparam logic [7:0] CTRL_GAP = 8'h70;
   localparam logic [7:0] PORT3_MODE = 8'hf7;
   localparam logic [7:0] BUS_MODE = 8'hf8;
   localparam logic [7:0] REG_POINTER = 8'hfd;
   localparam logic [7:0] STACK_POINTER_HIGH = 8'hfe;
   localparam logic [7:0] STACK_POINTER_LOW = 8'hff;
   localparam int RF_DEPTH = 144;
   localparam int GROUP_COUNT = 9;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   ////////////////////////////////////////////////////////////////
   // Mode bit positions
   localparam int BUS_FLOAT_BIT = 0;
   localparam int P0_FULL_BIT = 1;
   localparam int STACK_INT_BIT = 2;
   localparam int DM_ENABLE_BIT = 0;
   localparam int P3_DM_LINE = 4;
   ////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {
      KIND_FETCH = 2'b00,
      KIND_DATA = 2'b01,
      KIND_PUSH = 2'b10,
      KIND_POP = 2'b11
   } xmb_kind_t;
   typedef enum logic [1:0] {
      PH_T1 = 2'b00,
      PH_T2 = 2'b01,
      PH_T3 = 2'b10
   } xmb_phase_t;
   typedef struct packed {
      logic as_b_o;
      logic as_b_oe;
      logic ds_b_o;
      logic ds_b_oe;
      logic rw_o;
      logic rw_oe;
   } xmb_strobe_t;
   typedef struct packed {
      xmb_kind_t kind;
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } xmb_req_t;
endpackage

/* File: bench/xmb_bus_properties.sv */
// Port checks of the external memory bus sequencer
`timescale 1ns/1ps
module xmb_bus_chk #(
   parameter int PHASE_DIV = 2
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Requests and answers
   input wire logic i_req_valid,
   input wire xmb_pkg::xmb_req_t i_req,
   input wire logic o_req_ready,
   input wire logic o_rsp_valid,
   // Program counter
   input wire logic i_pc_load,
   input wire logic [15:0] i_pc_value,
   input wire logic i_vec_take,
   input wire logic [2:0] i_vec_id,
   input wire logic [15:0] o_pc,
   // Strobes
   input wire xmb_pkg::xmb_strobe_t o_strobe
);
   localparam int MC_LAST = 3 * PHASE_DIV - 1;
   localparam int RSP_LAT = 2 * PHASE_DIV + 1;
   logic as_d_reg, as_d_next, seen_reg, seen_next, take, ext, fall;
   logic [7:0] cyc_reg, cyc_next;
   assign take = o_req_ready && i_req_valid;
   assign fall = as_d_reg && !o_strobe.as_b_o;
   assign ext = (i_req.kind == xmb_pkg::KIND_DATA) ||
      (i_req.kind == xmb_pkg::KIND_FETCH && i_req.addr >= xmb_pkg::ROM_LIMIT);
   always_comb begin
      as_d_next = o_strobe.as_b_o;
      seen_next = seen_reg || fall;
      cyc_next = fall ? 8'h00 : cyc_reg + 8'h01;
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         as_d_reg <= 1'b1;
         seen_reg <= 1'b0;
         cyc_reg <= 8'h00;
      end else begin
         as_d_reg <= as_d_next;
         seen_reg <= seen_next;
         cyc_reg <= cyc_next;
      end
   end
   ////////////////////////////////////////
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   a_as_period: assert property (fall && seen_reg |-> cyc_reg == MC_LAST)
      else $error("address strobe period wrong");
   a_as_gap: assert property (seen_reg |-> cyc_reg <= MC_LAST)
      else $error("address strobe missing");
   a_ready_slot: assert property (o_req_ready |-> seen_reg && cyc_reg == PHASE_DIV - 2)
      else $error("ready outside end of first phase");
   a_ds_slot: assert property ($fell(o_strobe.ds_b_o) |-> cyc_reg == PHASE_DIV - 1)
      else $error("data strobe outside second phase");
   a_rsp_time: assert property (take |-> ##RSP_LAT o_rsp_valid)
      else $error("answer late or missing");
   a_wr_low: assert property (take && i_req.write && i_req.kind == xmb_pkg::KIND_DATA |-> ##1
      !o_strobe.rw_o && !o_strobe.ds_b_o)
      else $error("write line not low in write");
   a_ext_ds: assert property (take && ext |-> ##1 !o_strobe.ds_b_o)
      else $error("external transfer without data strobe");
   a_int_fetch: assert property (take && !ext && i_req.kind == xmb_pkg::KIND_FETCH |->
      ##1 o_strobe.ds_b_o [*2])
      else $error("internal fetch used data strobe");
   a_reset_pc: assert property ($rose(i_rst_b) |-> o_pc == xmb_pkg::RESET_PC)
      else $error("start address wrong");
   a_pc_load: assert property (i_pc_load && !i_vec_take |=> o_pc == $past(i_pc_value))
      else $error("counter load lost");
   a_vec_take: assert property (i_vec_take |=> o_pc == {12'h000, $past(i_vec_id), 1'b0})
      else $error("vector address wrong");
   c_ext_write: cover property (take && ext && i_req.write);
   c_int_fetch: cover property (take && !ext);
   c_vector: cover property (i_vec_take);
endmodule
bind xmb_bus xmb_bus_chk #(.PHASE_DIV(PHASE_DIV)) u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
   .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
   .i_pc_load(i_pc_load), .i_pc_value(i_pc_value), .i_vec_take(i_vec_take), .i_vec_id(i_vec_id),
   .o_pc(o_pc), .o_strobe(o_strobe));

/* File: bench/xmb_ext_mem.sv */
// External memory model on the multiplexed port lines
`timescale 1ns/1ps
module xmb_ext_mem (
   // Bus from the device
   input wire xmb_pkg::xmb_strobe_t i_strobe,
   input wire logic [7:0] i_port0,
   input wire logic [7:0] i_ad,
   // Read data toward port 1
   output logic [7:0] o_data,
   output logic o_data_oe,
   output logic [15:0] o_lat_addr
);
   logic [7:0] mem [0:65535];
   initial begin
      o_lat_addr = 16'h0000;
      for (int i = 0; i < 65536; i++) begin
         mem[i] = i[7:0] ^ i[15:8] ^ 8'h5a;
      end
   end
   always @(posedge i_strobe.as_b_o) o_lat_addr = {i_port0, i_ad};
   always @(i_strobe or i_ad or o_lat_addr) begin
      if (!i_strobe.ds_b_o && !i_strobe.rw_o) begin
         mem[o_lat_addr] = i_ad;
      end
   end
   assign o_data_oe = !i_strobe.ds_b_o && i_strobe.rw_o;
   assign o_data = mem[o_lat_addr];
endmodule

/* File: bench/xmb_bus_tb.sv */
// Self-checking bench of the external memory bus sequencer
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module xmb_bus_tb;
   typedef struct packed {logic [1:0] k; logic w; logic [15:0] a; logic [7:0] d; logic [7:0] e;} xmb_row_t;
   logic clk, rst_b, req_valid, rdy, rsp_valid, pc_load, vec_take, rf_short, rf_we, p1_oe, mem_oe, p3l4, dm;
   xmb_pkg::xmb_req_t req;
   xmb_pkg::xmb_strobe_t strobe;
   logic [7:0] rsp_data, rom_data, rf_rdata, p1_out, p1_wire, mem_data, rf_addr, rf_wdata, got, p0, p0_oe;
   logic [7:0] last_p1 = 8'h00;
   logic [15:0] pc, pc_value, lat_addr;
   logic [10:0] rom_addr;
   logic [2:0] vec_id;
   logic [3:0] rf_field;
   int num_errors = 0;
   int n_checks = 0;
   xmb_row_t rows [9] = '{'{2'b01, 1'b1, 16'h0900, 8'ha5, 8'ha5}, '{2'b01, 1'b0, 16'h0900, 8'h00, 8'ha5},
      '{2'b00, 1'b0, 16'h0900, 8'h00, 8'ha5}, '{2'b00, 1'b0, 16'h000c, 8'h00, 8'hcf},
      '{2'b00, 1'b0, 16'h07ff, 8'h00, 8'h3b}, '{2'b00, 1'b0, 16'h0800, 8'h00, 8'h52},
      '{2'b01, 1'b0, 16'hffff, 8'h00, 8'h5a}, '{2'b01, 1'b1, 16'h1234, 8'h3c, 8'h3c},
      '{2'b01, 1'b0, 16'h1234, 8'h00, 8'h3c}};
   assign rom_data = rom_addr[7:0] ^ {5'h00, rom_addr[10:8]} ^ 8'hc3;
   assign p1_wire = p1_oe ? p1_out : (mem_oe ? mem_data : ~last_p1);
   always @(posedge clk) last_p1 <= p1_wire;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   xmb_bus #(.PHASE_DIV(2)) uut (.i_clk(clk), .i_rst_b(rst_b), .i_req_valid(req_valid), .i_req(req),
      .o_req_ready(rdy), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .i_pc_load(pc_load),
      .i_pc_value(pc_value), .i_vec_take(vec_take), .i_vec_id(vec_id), .o_pc(pc), .o_rom_addr(rom_addr),
      .i_rom_data(rom_data), .i_rf_short(rf_short), .i_rf_addr(rf_addr), .i_rf_field(rf_field),
      .i_rf_we(rf_we), .i_rf_wdata(rf_wdata), .o_rf_rdata(rf_rdata), .o_strobe(strobe), .o_port0(p0),
      .o_port0_oe(p0_oe), .i_port1(p1_wire), .o_port1(p1_out), .o_port1_oe(p1_oe), .o_port3_line4(p3l4));
   xmb_ext_mem mem_u (.i_strobe(strobe), .i_port0(p0), .i_ad(p1_wire), .o_data(mem_data),
      .o_data_oe(mem_oe), .o_lat_addr(lat_addr));
   ////////////////////////////////////////
   task automatic complete_run();
      if (num_errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic xfer(input logic [1:0] k, input logic w, input logic [15:0] a, input logic [7:0] d,
         output logic [7:0] rd);
      int n;
      n = 0;
      @(negedge clk);
      while (strobe.as_b_o !== 1'b0 && n < 20) begin
         @(negedge clk);
         n++;
      end
      req = {k, w, a, d};
      req_valid = 1'b1;
      while (rdy !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      req_valid = 1'b0;
      dm = p3l4;
      while (rsp_valid !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      rd = rsp_data;
   endtask
   task automatic rf(input logic s, input logic w, input logic [7:0] a, input logic [7:0] d,
         output logic [7:0] rd);
      @(negedge clk);
      rf_short = s;
      rf_field = a[3:0];
      rf_addr = a;
      rf_we = w;
      rf_wdata = d;
      @(negedge clk);
      rf_we = 1'b0;
      rd = rf_rdata;
   endtask
   initial begin
      #100000;
      num_errors++;
      complete_run();
   end
   initial begin
      {rst_b, req_valid, req, pc_load, pc_value, vec_take, vec_id} = '0;
      {rf_short, rf_addr, rf_field, rf_we, rf_wdata} = '0;
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
      `CHK(pc, xmb_pkg::RESET_PC);
      `CHK(strobe.rw_o, 1'b1);
      rf(1'b0, 1'b1, xmb_pkg::BUS_MODE, 8'h02, got);
      foreach (rows[i]) begin
         if (rows[i].k == 2'b00) begin
            pc_load = 1'b1;
            pc_value = rows[i].a;
            @(negedge clk);
            pc_load = 1'b0;
         end
         xfer(rows[i].k, rows[i].w, rows[i].a, rows[i].d, got);
         `CHK(got, rows[i].e);
         if (rows[i].k == 2'b01 || rows[i].a >= xmb_pkg::ROM_LIMIT)
            `CHK(lat_addr, rows[i].a);
      end
      rf(1'b0, 1'b1, xmb_pkg::STACK_POINTER_HIGH, 8'h10, got);
      rf(1'b0, 1'b1, xmb_pkg::STACK_POINTER_LOW, 8'h00, got);
      xfer(2'b10, 1'b1, 16'h0000, 8'h77, got);
      xfer(2'b01, 1'b0, 16'h0fff, 8'h00, got);
      `CHK(got, 8'h77);
      xfer(2'b11, 1'b0, 16'h0000, 8'h00, got);
      `CHK(got, 8'h77);
      rf(1'b0, 1'b0, xmb_pkg::STACK_POINTER_LOW, 8'h00, got);
      `CHK(got, 8'h00);
      rf(1'b0, 1'b1, xmb_pkg::BUS_MODE, 8'h06, got);
      rf(1'b0, 1'b1, xmb_pkg::STACK_POINTER_LOW, 8'h20, got);
      xfer(2'b10, 1'b1, 16'h0000, 8'h5a, got);
      rf(1'b0, 1'b0, 8'h1f, 8'h00, got);
      `CHK(got, 8'h5a);
      rf(1'b0, 1'b1, xmb_pkg::REG_POINTER, 8'h10, got);
      rf(1'b1, 1'b1, 8'h03, 8'h66, got);
      rf(1'b0, 1'b0, 8'h13, 8'h00, got);
      `CHK(got, 8'h66);
      rf(1'b0, 1'b1, 8'h7f, 8'h11, got);
      rf(1'b0, 1'b0, 8'h7f, 8'h00, got);
      `CHK(got, 8'h11);
      rf(1'b0, 1'b1, 8'h80, 8'h99, got);
      rf(1'b0, 1'b0, 8'h80, 8'h00, got);
      `CHK(got, 8'h00);
      rf(1'b0, 1'b1, xmb_pkg::PORT3_MODE, 8'h01, got);
      xfer(2'b01, 1'b0, 16'h0900, 8'h00, got);
      `CHK(dm, 1'b0);
      xfer(2'b00, 1'b0, 16'h0900, 8'h00, got);
      `CHK(dm, 1'b1);
      rf(1'b0, 1'b1, xmb_pkg::BUS_MODE, 8'h03, got);
      @(negedge clk);
      `CHK({strobe.as_b_oe, strobe.ds_b_oe, strobe.rw_oe, p1_oe}, 4'h0);
      `CHK(p0_oe, 8'h00);
      rf(1'b0, 1'b1, xmb_pkg::BUS_MODE, 8'h02, got);
      pc_load = 1'b1;
      pc_value = 16'h1234;
      @(negedge clk);
      pc_load = 1'b0;
      `CHK(pc, 16'h1234);
      {pc_load, vec_take, vec_id} = {1'b1, 1'b1, 3'h5};
      @(negedge clk);
      {pc_load, vec_take} = 2'b00;
      `CHK(pc, 16'h000a);
      complete_run();
   end
endmodule
